//--- hdl/service_request_cfg.svh
/*
 Constants of the service request unit: status byte bit positions,
 enable reset values and octal digit codes.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SERVICE_REQUEST_CFG_SVH
`define SERVICE_REQUEST_CFG_SVH

// ----------------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------------
`define SRB_UNITS_BIT    1
`define SRB_SWEEP_BIT    2
`define SRB_FAULT_BIT    3
`define SRB_ILLEGAL_BIT  5
`define SRB_RQS_BIT      6
`define SRB_EVENT_MASK   8'h2E

// ----------------------------------------------------------------------
// Reset and preset values
// ----------------------------------------------------------------------
`define EN_SWEEP_RST     1'b0
`define EN_FAULT_RST     1'b0
`define EN_UNITS_RST     1'b0
`define EN_FAULT_PRESET  1'b1
`define STATUS_RST       8'h00

// ----------------------------------------------------------------------
// Annotation character codes
// ----------------------------------------------------------------------
`define ASCII_ZERO       8'h30

`endif

//--- hdl/service_request_pkg.sv
/*
 Types of the service request unit.
 Assumes service_request_cfg.svh is on the include path.
*/
package service_request_pkg;

	// ----------------------------------------------------------------------
	// Event pulses from the instrument
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic sweep_end;
		logic cal_done;
		logic avg_done;
		logic units_key;
		logic hw_fault;
		logic illegal_cmd;
		logic local_srq_key;
	} event_t;

	// ----------------------------------------------------------------------
	// Remote commands from the parser
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic disable_all;
		logic sweep_en;
		logic fault_en;
		logic units_en;
	} cmd_t;

	// ----------------------------------------------------------------------
	// Screen annotation
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic       show;
		logic [7:0] digit2;
		logic [7:0] digit1;
		logic [7:0] digit0;
	} annot_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b01,
		ST_REQUEST = 2'b10
	} srq_state_t;

endpackage

//--- hdl/octal_annot.sv
/*
 Converts the status byte into three ASCII octal digits for the screen.
 Assumes the byte is stable while shown; output is registered.
*/
`timescale 1ns/1ps
`default_nettype none
`include "service_request_cfg.svh"

module octal_annot (
	input  wire logic                        ref_clk,
	input  wire logic                        sys_rst,
	input  wire logic [7:0]                  status,
	input  wire logic                        show,
	output var  service_request_pkg::annot_t annot
);

	service_request_pkg::annot_t annot_nxt;

	// ----------------------------------------------------------------------
	// Octal split: bits 7:6, 5:3 and 2:0
	// ----------------------------------------------------------------------
	always_comb begin
		annot_nxt.show   = show;
		annot_nxt.digit2 = `ASCII_ZERO + {6'h00, status[7:6]};
		annot_nxt.digit1 = `ASCII_ZERO + {5'h00, status[5:3]};
		annot_nxt.digit0 = `ASCII_ZERO + {5'h00, status[2:0]};
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			annot <= '0;
		end else begin
			annot <= annot_nxt;
		end
	end

endmodule
`default_nettype wire

//--- hdl/service_request_unit.sv
/*
 Service request unit: event latching, enable commands, request line,
 serial poll status byte and on-screen request code.
 Assumes event and command inputs are one-cycle pulses synchronous to
 ref_clk, and the bus interface pulses serial_poll_rd once per poll.
*/
// How it works
// - Pending request asserts service-request line
// - Event bits 1,2,3,5; bits 0,4,7 zero
// - Bit 6 set whenever request reported
// - Screen shows status byte as octal
// - Blanked annotation hides code, line stays
// - Simultaneous requests share one status byte
// - Byte only by serial poll; parallel ignored
// - Illegal command always enabled, local request by local mode, others gated
// - Disable-all clears three enables
// - Sweep and fault enables persist
// - Units enable clears on key, serial poll, disable
// - Enables independent of each other
// - Preset sets fault enable
// - Calibration and averaging count as sweep
// - Status read releases request line unless an event latches in the same cycle
// - Local front-panel request raises units bit in local mode
`timescale 1ns/1ps
`default_nettype none
`include "service_request_cfg.svh"

module service_request_unit (
	input  wire logic                         ref_clk,
	input  wire logic                         sys_rst,
	input  wire service_request_pkg::event_t  events,
	input  wire service_request_pkg::cmd_t    cmds,
	input  wire logic                         preset,
	input  wire logic                         local_mode,
	input  wire logic                         annot_blank,
	input  wire logic                         serial_poll_rd,
	input  wire logic                         parallel_poll_rd,
	output logic                              srq_n,
	output logic [7:0]                        request_status_byte,
	output logic                              status_valid,
	output service_request_pkg::annot_t       annot,
	output logic [2:0]                        enables
);

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	logic                            en_sweep_r, en_sweep_nxt;
	logic                            en_fault_r, en_fault_nxt;
	logic                            en_units_r, en_units_nxt;
	logic [7:0]                      status_r, status_nxt;
	logic [7:0]                      rd_byte_r, rd_byte_nxt;
	logic                            valid_r, valid_nxt;
	logic                            srq_n_r, srq_n_nxt;
	service_request_pkg::srq_state_t state_r, state_nxt;
	logic [7:0]                      raised;
	logic                            sweep_ev;
	logic                            units_ev;

	// ----------------------------------------------------------------------
	// Enables
	// ----------------------------------------------------------------------
	always_comb begin
		en_sweep_nxt = en_sweep_r;
		en_fault_nxt = en_fault_r;
		en_units_nxt = en_units_r;
		if (cmds.sweep_en) begin
			en_sweep_nxt = 1'b1;
		end
		if (cmds.fault_en || preset) begin
			en_fault_nxt = 1'b1;
		end
		if (events.units_key || serial_poll_rd) begin
			en_units_nxt = 1'b0;
		end
		if (cmds.units_en) begin
			en_units_nxt = 1'b1;
		end
		if (cmds.disable_all) begin
			en_sweep_nxt = 1'b0;
			en_fault_nxt = 1'b0;
			en_units_nxt = 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// Event latching and request state
	// ----------------------------------------------------------------------
	always_comb begin
		sweep_ev = events.sweep_end || events.cal_done || events.avg_done;
		units_ev = (events.units_key && en_units_r)
			|| (events.local_srq_key && local_mode);
		raised = 8'h00;
		raised[`SRB_UNITS_BIT]   = units_ev;
		raised[`SRB_SWEEP_BIT]   = sweep_ev && en_sweep_r;
		raised[`SRB_FAULT_BIT]   = events.hw_fault && en_fault_r;
		raised[`SRB_ILLEGAL_BIT] = events.illegal_cmd;
		status_nxt  = status_r;
		rd_byte_nxt = rd_byte_r;
		valid_nxt   = 1'b0;
		state_nxt   = state_r;
		if (serial_poll_rd) begin
			rd_byte_nxt = status_r;
			if (status_r != `STATUS_RST) begin
				rd_byte_nxt[`SRB_RQS_BIT] = 1'b1;
			end
			valid_nxt  = 1'b1;
			status_nxt = `STATUS_RST;
		end
		status_nxt = (status_nxt | raised) & `SRB_EVENT_MASK;
		case (state_r)
			service_request_pkg::ST_IDLE: begin
				if (status_nxt != `STATUS_RST) begin
					state_nxt = service_request_pkg::ST_REQUEST;
				end
			end
			service_request_pkg::ST_REQUEST: begin
				if (status_nxt == `STATUS_RST) begin
					state_nxt = service_request_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = service_request_pkg::ST_IDLE;
			end
		endcase
		srq_n_nxt = !(state_nxt == service_request_pkg::ST_REQUEST);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			en_sweep_r <= `EN_SWEEP_RST;
			en_fault_r <= `EN_FAULT_RST;
			en_units_r <= `EN_UNITS_RST;
			status_r   <= `STATUS_RST;
			rd_byte_r  <= `STATUS_RST;
			valid_r    <= 1'b0;
			srq_n_r    <= 1'b1;
			state_r    <= service_request_pkg::ST_IDLE;
		end else begin
			en_sweep_r <= en_sweep_nxt;
			en_fault_r <= en_fault_nxt;
			en_units_r <= en_units_nxt;
			status_r   <= status_nxt;
			rd_byte_r  <= rd_byte_nxt;
			valid_r    <= valid_nxt;
			srq_n_r    <= srq_n_nxt;
			state_r    <= state_nxt;
		end
	end

	// ----------------------------------------------------------------------
	// Screen annotation
	// ----------------------------------------------------------------------
	logic [7:0] shown_byte;

	always_comb begin
		shown_byte = status_r;
		shown_byte[`SRB_RQS_BIT] = (status_r != `STATUS_RST);
	end

	octal_annot u_annot (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.status  (shown_byte),
		.show    ((status_r != `STATUS_RST) && !annot_blank),
		.annot   (annot)
	);

	// Parallel poll input is deliberately left unused
	assign srq_n               = srq_n_r;
	assign request_status_byte = rd_byte_r;
	assign status_valid        = valid_r;
	assign enables             = {en_units_r, en_fault_r, en_sweep_r};

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_poll;
		serial_poll_rd ##1 valid_r;
	endsequence

	sequence s_cal_sweep;
		(events.cal_done || events.avg_done) && en_sweep_r;
	endsequence

	a_srq_follows_status: assert property (
		(status_r != 8'h00) |-> !srq_n_r) else $error("srq not asserted");
	a_unused_bits_zero: assert property (
		valid_r |-> (rd_byte_r & 8'h91) == 8'h00) else $error("unused bits set");
	a_rqs_bit_set: assert property (
		(serial_poll_rd && status_r != 8'h00) |=> rd_byte_r[6]) else $error("rqs bit low");
	a_poll_clears: assert property (
		(serial_poll_rd && !(|raised)) |=> status_r == 8'h00 && srq_n_r) else $error("poll no release");
	a_poll_valid: assert property (
		serial_poll_rd |-> s_poll) else $error("poll not answered");
	a_no_parallel: assert property (
		(parallel_poll_rd && !serial_poll_rd) |=> !valid_r) else $error("parallel answered");
	a_illegal_latch: assert property (
		events.illegal_cmd |=> status_r[5]) else $error("illegal lost");
	a_disable_all: assert property (
		cmds.disable_all |=> enables == 3'b000) else $error("enables kept");
	a_preset_fault: assert property (
		(preset && !cmds.disable_all) |=> en_fault_r) else $error("preset no fault");
	a_units_once: assert property (
		(events.units_key && !cmds.units_en) |=> !en_units_r) else $error("units not cleared");
	a_blank_hides: assert property (
		annot_blank |=> !annot.show) else $error("code shown");
	a_sweep_gate: assert property (
		(!en_sweep_r && status_r[2] == 1'b0) |=> !status_r[2]) else $error("sweep ungated");
	a_cal_as_sweep: assert property (
		s_cal_sweep |=> status_r[2]) else $error("cal or avg lost");
	a_local_units: assert property (
		(events.local_srq_key && local_mode) |=> status_r[1]) else $error("local request lost");
	a_sweep_persist: assert property (
		(en_sweep_r && !cmds.disable_all) |=> en_sweep_r) else $error("sweep enable lost");

endmodule
`default_nettype wire

//--- tb/poll_controller.sv
/*
 Bus controller model that serial polls the unit while srq_n is low.
 Assumes one ref_clk domain and the registered poll answer of the unit.
*/
`timescale 1ns/1ps
`default_nettype none

module poll_controller (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       poll_go,
	input  wire logic       srq_n,
	input  wire logic       status_valid,
	input  wire logic [7:0] request_status_byte,
	output logic            serial_poll_rd,
	output logic [7:0]      byte_seen
);
	// ----------------------------------------------------------------------
	// Serial poll only, one poll in flight
	// ----------------------------------------------------------------------
	logic busy_r;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			serial_poll_rd <= 1'b0;
			busy_r         <= 1'b0;
			byte_seen      <= 8'h00;
		end else begin
			serial_poll_rd <= poll_go && !srq_n && !busy_r;
			if (poll_go && !srq_n && !busy_r) begin
				busy_r <= 1'b1;
			end
			if (status_valid) begin
				busy_r    <= 1'b0;
				byte_seen <= request_status_byte;
			end
		end
	end
endmodule

`default_nettype wire

//--- tb/test_service_request_unit.sv
/*
 Self-checking bench of the service request unit with a polling model.
 Assumes the design files and package are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none

module test_service_request_unit;
	// ----------------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] c;
		logic [6:0] e;
		logic       l;
		logic       b;
		logic [7:0] x;
	} row_t;
	logic                        ref_clk, sys_rst, preset, local_mode, annot_blank;
	logic                        serial_poll_rd, parallel_poll_rd, poll_go, srq_n, status_valid;
	service_request_pkg::event_t events;
	service_request_pkg::cmd_t   cmds;
	service_request_pkg::annot_t annot;
	logic [7:0]                  request_status_byte, byte_seen;
	logic [2:0]                  enables;
	int                          err_total, check_count, cycles;
	row_t                        rows [11];
	row_t                        r;

	service_request_unit i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .events(events),
		.cmds(cmds), .preset(preset), .local_mode(local_mode), .annot_blank(annot_blank),
		.serial_poll_rd(serial_poll_rd), .parallel_poll_rd(parallel_poll_rd), .srq_n(srq_n),
		.request_status_byte(request_status_byte), .status_valid(status_valid),
		.annot(annot), .enables(enables));
	poll_controller i_ctl (.ref_clk(ref_clk), .sys_rst(sys_rst), .poll_go(poll_go),
		.srq_n(srq_n), .status_valid(status_valid), .request_status_byte(request_status_byte),
		.serial_poll_rd(serial_poll_rd), .byte_seen(byte_seen));

	// ----------------------------------------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			err_total = err_total + 1;
			summarize();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic chk(input string name, input logic [24:0] exp, input logic [24:0] got);
		check_count = check_count + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		rows = '{{4'h0, 7'h02, 1'b0, 1'b0, 8'h60}, {4'h4, 7'h42, 1'b0, 1'b0, 8'h64},
			{4'h2, 7'h04, 1'b0, 1'b0, 8'h48}, {4'h1, 7'h08, 1'b0, 1'b0, 8'h42},
			{4'h4, 7'h20, 1'b0, 1'b0, 8'h44}, {4'h4, 7'h10, 1'b0, 1'b0, 8'h44},
			{4'h0, 7'h4C, 1'b0, 1'b0, 8'h00}, {4'h7, 7'h4E, 1'b0, 1'b0, 8'h6E},
			{4'h0, 7'h01, 1'b1, 1'b0, 8'h42}, {4'h0, 7'h01, 1'b0, 1'b0, 8'h00},
			{4'h0, 7'h02, 1'b0, 1'b1, 8'h60}};
		{sys_rst, preset, local_mode, annot_blank, parallel_poll_rd, poll_go} = 6'h20;
		events = '0;
		cmds = '0;
		{err_total, check_count, cycles} = '0;
		cyc(2);
		sys_rst = 1'b0;
		chk("reset", 25'h1000000, {srq_n, request_status_byte, status_valid, enables, 12'h000});
		chk("reset annot", 25'h0, annot);
		preset = 1'b1;
		cyc(1);
		preset = 1'b0;
		cyc(1);
		chk("preset enables", 25'h2, enables);
		foreach (rows[i]) begin
			r = rows[i];
			cmds = 4'h8;
			cyc(1);
			cmds = r.c;
			cyc(1);
			{cmds, local_mode, annot_blank} = {4'h0, r.l, r.b};
			cyc(1);
			chk("enables", {r.c[0], r.c[1], r.c[2]}, enables);
			events = r.e;
			cyc(1);
			events = '0;
			cyc(4);
			chk("srq_n", r.x == 8'h00, srq_n);
			chk("show", r.x != 8'h00 && !r.b, annot.show);
			if (r.x != 8'h00) begin
				chk("digits", {8'h30 + r.x[7:6], 8'h30 + r.x[5:3], 8'h30 + r.x[2:0]},
					{annot.digit2, annot.digit1, annot.digit0});
			end
			poll_go = 1'b1;
			cyc(6);
			poll_go = 1'b0;
			if (r.x != 8'h00) begin
				chk("byte", r.x, byte_seen);
			end
			chk("released", 25'h1, srq_n);
			chk("enables after", {1'b0, r.c[1], r.c[2]}, enables);
		end
		events = 7'h02;
		cyc(1);
		events = '0;
		cyc(3);
		parallel_poll_rd = 1'b1;
		cyc(1);
		parallel_poll_rd = 1'b0;
		chk("parallel", 25'h0, {status_valid, srq_n});
		cyc(3);
		chk("parallel hold", 25'h0, {status_valid, srq_n});
		poll_go = 1'b1;
		cyc(1);
		{poll_go, events} = {1'b0, 7'h02};
		cyc(1);
		events = '0;
		cyc(3);
		chk("poll collision", 25'h0C0, {byte_seen, srq_n});
		sys_rst = 1'b1;
		cyc(2);
		sys_rst = 1'b0;
		chk("reset again", 25'h1000000,
			{srq_n, request_status_byte, status_valid, enables, 12'h000});
		chk("reset annot again", 25'h0, annot);
		summarize();
	end
endmodule

`default_nettype wire
